// [scr_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_config_regs #(
   parameter int unsigned CYC_PER_SEC = scr_pkg::CYC_PER_SEC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   input  wire logic        regNv,
   output logic             regBusy,
   output logic [15:0]      regRdData,
   output logic             regRdValid,
   output logic [7:0]       nvmAddr,
   output logic             nvmRdEn,
   output logic             nvmWrEn,
   output logic [21:0]      nvmWrData,
   input  wire logic [21:0] nvmRdData,
   input  wire logic        converterRegulatorOn,
   input  wire logic [11:0] objTemp,
   input  wire logic [11:0] ambTemp,
   input  wire logic [11:0] compThreshold,
   input  wire logic [11:0] relayThrNvm,
   input  wire logic [11:0] relayThrPin,
   output logic             convRefDriveEn,
   output logic             convRefPinInput,
   output logic             batteryRegulatorOn,
   output logic             adcRefInternal,
   output logic             relayThrFromPin,
   output logic             tempChainBypass,
   output logic             memWriteEnabledFlag,
   output logic             testModeFlag,
   output logic             fatalErrorFlag,
   output logic [3:0]       objPinSel,
   output logic [3:0]       ambPinSel,
   output logic             thermistorNtc,
   output logic             curvatureNegative,
   output logic             offsetCalStart,
   output logic             outputComparator,
   output logic             outputRelay,
   output logic [15:0]      oscillator_control,
   output logic [15:0]      refTrim
);
   typedef enum logic [2:0] {SLOAD, SLOADCAP, SIDLE, SNVRD, SNVCAP, SNVWR} scr_state_t;

   function automatic logic [21:0] hamEnc(input logic [15:0] d);
      logic [21:0] c;
      int          j;
      c = '0;
      j = 0;
      for (int p = 1; p <= scr_pkg::CW_H; p++) begin
         if ((p & (p - 1)) != 0) begin
            c[p-1] = d[j];
            j++;
         end
      end
      for (int k = 0; k < scr_pkg::HAM_P; k++) begin
         for (int p = 1; p <= scr_pkg::CW_H; p++) begin
            if ((p & (1 << k)) != 0) c[(1<<k)-1] = c[(1<<k)-1] ^ c[p-1];
         end
      end
      c[scr_pkg::CW-1] = ^c[scr_pkg::CW_H-1:0];
      return c;
   endfunction

   // Returns {double error, corrected data}
   function automatic logic [16:0] hamDec(input logic [21:0] cw);
      logic [21:0] c;
      logic [4:0]  syn;
      logic [15:0] d;
      logic        par;
      int          j;
      c   = cw;
      syn = 5'h00;
      d   = 16'h0000;
      j   = 0;
      par = ^cw;
      for (int p = 1; p <= scr_pkg::CW_H; p++) begin
         if (c[p-1]) syn = syn ^ 5'(p);
      end
      if (par && syn != 5'h00 && int'(syn) <= scr_pkg::CW_H) c[syn-5'h01] = ~c[syn-5'h01];
      for (int p = 1; p <= scr_pkg::CW_H; p++) begin
         if ((p & (p - 1)) != 0) begin
            d[j] = c[p-1];
            j++;
         end
      end
      return {(!par && syn != 5'h00), d};
   endfunction

   function automatic logic [3:0] pinSel(input logic [1:0] f);
      return 4'h1 << f;
   endfunction

   function automatic logic cmpOut(input logic [11:0] t, input logic [11:0] th,
                                   input logic nonInv);
      return nonInv ? (t > th) : !(t > th);
   endfunction

   logic        rstMeta_n;
   logic        rstSync_n;
   scr_state_t  state_q;
   scr_state_t  state_d;
   logic [7:0]  addr_q;
   logic [7:0]  addr_d;
   logic [15:0] conf0_q;
   logic [15:0] conf0_d;
   logic [15:0] conf1_q;
   logic [15:0] conf1_d;
   logic [15:0] osc_q;
   logic [15:0] osc_d;
   logic [15:0] bgo_q;
   logic [15:0] bgo_d;
   logic        fatal_q;
   logic        fatal_d;
   logic        memWe_q;
   logic        memWe_d;
   logic        test_q;
   logic        test_d;
   logic [15:0] rdData_q;
   logic [15:0] rdData_d;
   logic        rdValid_q;
   logic        rdValid_d;
   logic [21:0] wrCw_q;
   logic [21:0] wrCw_d;
   logic        cmp_q;
   logic        cmp_d;
   logic        rel_q;
   logic        rel_d;
   logic [16:0] dec;
   logic        dbl;
   logic        nvOk;
   logic        fatalSet;
   logic [15:0] rdWord;
   logic [11:0] relThr;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   assign dec = hamDec(nvmRdData);
   assign dbl = dec[16];
   // Oscillator and trim words also need test mode for an NV write
   assign nvOk = memWe_q && ((addr_q != scr_pkg::A_OSC && addr_q != scr_pkg::A_BGO) || test_q);

   always_comb begin
      rdWord = 16'h0000;
      unique case (regAddr)
         scr_pkg::A_CONF0: rdWord = conf0_q;
         scr_pkg::A_CONF1: begin
            rdWord = conf1_q;
            rdWord[scr_pkg::C1_FATAL] = fatal_q;
            rdWord[scr_pkg::C1_MEMWE] = memWe_q;
            rdWord[scr_pkg::C1_TEST]  = test_q;
         end
         default: rdWord = 16'h0000;
      endcase
   end

   always_comb begin
      state_d   = state_q;
      addr_d    = addr_q;
      conf0_d   = conf0_q;
      conf1_d   = conf1_q;
      osc_d     = osc_q;
      bgo_d     = bgo_q;
      fatal_d   = fatal_q;
      memWe_d   = memWe_q;
      test_d    = test_q;
      rdData_d  = rdData_q;
      rdValid_d = 1'b0;
      wrCw_d    = wrCw_q;
      fatalSet  = 1'b0;
      unique case (state_q)
         SLOAD: state_d = SLOADCAP;
         SLOADCAP: begin
            // A word with a multi-bit failure is not loaded
            if (dbl) begin
               fatalSet = 1'b1;
            end else begin
               unique case (addr_q)
                  scr_pkg::A_CONF0: conf0_d = dec[15:0] & scr_pkg::C0_MASK;
                  scr_pkg::A_CONF1: conf1_d = dec[15:0] & scr_pkg::C1_NV_MASK;
                  scr_pkg::A_OSC:   osc_d   = dec[15:0];
                  default:          bgo_d   = dec[15:0];
               endcase
            end
            if (addr_q == scr_pkg::NV_LAST) begin
               state_d = SIDLE;
            end else begin
               addr_d  = addr_q + 8'h01;
               state_d = SLOAD;
            end
         end
         SIDLE: begin
            if (regRd && regNv) begin
               addr_d  = regAddr;
               state_d = SNVRD;
            end else if (regRd) begin
               rdData_d  = rdWord;
               rdValid_d = 1'b1;
            end else if (regWr && regNv) begin
               addr_d  = regAddr;
               wrCw_d  = hamEnc(regWrData);
               state_d = SNVWR;
            end else if (regWr) begin
               unique case (regAddr)
                  scr_pkg::A_TEST: test_d  = (regWrData == scr_pkg::TEST_KEY);
                  scr_pkg::A_WP:   memWe_d = (regWrData == scr_pkg::WP_KEY);
                  scr_pkg::A_CONF0: if (test_q) conf0_d = regWrData & scr_pkg::C0_MASK;
                  scr_pkg::A_CONF1: if (test_q) begin
                     conf1_d = (regWrData & scr_pkg::C1_WR_MASK) |
                               (conf1_q & scr_pkg::C1_BT_MASK);
                  end
                  scr_pkg::A_OSC: if (test_q) osc_d = regWrData;
                  scr_pkg::A_BGO: if (test_q) bgo_d = regWrData;
                  default: ;
               endcase
            end
         end
         SNVRD: state_d = SNVCAP;
         SNVCAP: begin
            rdData_d  = dec[15:0];
            rdValid_d = 1'b1;
            fatalSet  = dbl;
            state_d   = SIDLE;
         end
         SNVWR: state_d = SIDLE;
         default: state_d = SIDLE;
      endcase
      if (test_q && !test_d && memWe_q) fatal_d = 1'b0;
      if (fatalSet) fatal_d = 1'b1;
   end

   // Address and write data latched so the NV cycle sees stable values
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_q   <= SLOAD;
         addr_q    <= scr_pkg::NV_FIRST;
         conf0_q   <= 16'h0000;
         conf1_q   <= scr_pkg::C1_RESET;
         osc_q     <= 16'h0000;
         bgo_q     <= 16'h0000;
         fatal_q   <= 1'b0;
         memWe_q   <= 1'b0;
         test_q    <= 1'b0;
         rdData_q  <= 16'h0000;
         rdValid_q <= 1'b0;
         wrCw_q    <= 22'h000000;
      end else begin
         state_q   <= state_d;
         addr_q    <= addr_d;
         conf0_q   <= conf0_d;
         conf1_q   <= conf1_d;
         osc_q     <= osc_d;
         bgo_q     <= bgo_d;
         fatal_q   <= fatal_d;
         memWe_q   <= memWe_d;
         test_q    <= test_d;
         rdData_q  <= rdData_d;
         rdValid_q <= rdValid_d;
         wrCw_q    <= wrCw_d;
      end
   end

   assign relThr = conf1_q[scr_pkg::C1_THRSRC] ? relayThrPin : relayThrNvm;

   always_comb begin
      cmp_d = cmpOut(conf1_q[scr_pkg::C1_CMPSRC] ? ambTemp : objTemp,
                     compThreshold, conf1_q[scr_pkg::C1_CMPPOL]);
      rel_d = cmpOut(conf1_q[scr_pkg::C1_RELSRC] ? ambTemp : objTemp,
                     relThr, conf1_q[scr_pkg::C1_RELPOL]);
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         cmp_q <= 1'b0;
         rel_q <= 1'b0;
      end else begin
         cmp_q <= cmp_d;
         rel_q <= rel_d;
      end
   end

   scr_cal_timer #(
      .CYC_PER_SEC (CYC_PER_SEC)
   ) u_timer (
      .clk       (clk),
      .rstSync_n (rstSync_n),
      .interval  (conf0_q[scr_pkg::C0_OSI +: 4]),
      .calStart  (offsetCalStart)
   );

   assign regBusy             = (state_q != SIDLE);
   assign regRdData           = rdData_q;
   assign regRdValid          = rdValid_q;
   assign nvmAddr             = addr_q;
   assign nvmRdEn             = (state_q == SLOAD) || (state_q == SNVRD);
   assign nvmWrEn             = (state_q == SNVWR) && nvOk;
   assign nvmWrData           = wrCw_q;
   // Reference pin is an input whenever the driver is stopped or unpowered
   assign convRefPinInput     = conf1_q[scr_pkg::C1_REFSTOP] || !converterRegulatorOn;
   assign convRefDriveEn      = !convRefPinInput;
   assign batteryRegulatorOn  = conf1_q[scr_pkg::C1_BATT];
   assign adcRefInternal      = conf1_q[scr_pkg::C1_ADCREF];
   assign relayThrFromPin     = conf1_q[scr_pkg::C1_THRSRC];
   assign tempChainBypass     = conf1_q[scr_pkg::C1_BYPASS];
   assign memWriteEnabledFlag = memWe_q;
   assign testModeFlag        = test_q;
   assign fatalErrorFlag      = fatal_q;
   assign objPinSel           = pinSel(conf0_q[scr_pkg::C0_OBJ +: 2]);
   assign ambPinSel           = pinSel(conf0_q[scr_pkg::C0_AMB +: 2]);
   assign thermistorNtc       = conf0_q[scr_pkg::C0_NTC];
   assign curvatureNegative   = conf0_q[scr_pkg::C0_NTC] ? conf0_q[scr_pkg::C0_CURVN]
                                                        : conf0_q[scr_pkg::C0_CURVP];
   assign outputComparator    = cmp_q;
   assign outputRelay         = rel_q;
   assign oscillator_control             = osc_q;
   assign refTrim             = bgo_q;

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstSync_n);

   battery_reset_a: assert property ($rose(rstSync_n) |-> batteryRegulatorOn)
      else $error("battery regulator off after reset");
   test_flag_a: assert property (!(regWr && !regNv && !regBusy
      && regAddr == scr_pkg::A_TEST) |=> $stable(testModeFlag))
      else $error("test flag moved without mode write");
   conf_write_a: assert property (regWr && !regNv && !regBusy && !testModeFlag
      && regAddr == scr_pkg::A_CONF0 |=> $stable(conf0_q))
      else $error("working write outside test mode");
   nv_unlock_a: assert property (nvmWrEn |-> memWriteEnabledFlag)
      else $error("NV write while protected");
   osc_nv_a: assert property (nvmWrEn && nvmAddr == scr_pkg::A_OSC |-> testModeFlag)
      else $error("oscillator NV write outside test mode");
   fatal_set_a: assert property (state_q == SNVCAP && dbl |=> fatalErrorFlag)
      else $error("multi-bit failure not flagged");
   fatal_clr_a: assert property ($fell(fatalErrorFlag) |-> $fell(testModeFlag)
      && $past(memWriteEnabledFlag))
      else $error("fatal flag cleared outside sequence");
   ref_stop_a: assert property (regWr && !regNv && !regBusy && testModeFlag
      && regAddr == scr_pkg::A_CONF1 && regWrData[scr_pkg::C1_REFSTOP]
      |=> !convRefDriveEn)
      else $error("reference driver still on");
   osc_read_a: assert property (regRd && !regNv && !regBusy && regAddr == scr_pkg::A_OSC
      |=> regRdValid && regRdData == 16'h0000)
      else $error("oscillator word read directly");
   nv_read_a: assert property (regRd && regNv && !regBusy |-> ##3 regRdValid)
      else $error("NV read answer late");
   cal_zero_a: assert property (offsetCalStart |-> $past(conf0_q[scr_pkg::C0_OSI +: 4])
      != 4'h0) else $error("calibration with zero interval");

   load_done_c: cover property ($rose(state_q == SIDLE));
   nv_read_c: cover property (state_q == SNVCAP && !dbl);
   fatal_c: cover property ($rose(fatalErrorFlag));
   cal_c: cover property (offsetCalStart);
endmodule
`default_nettype wire

// [scr_pkg.sv]
`default_nettype none
package scr_pkg;
   localparam int          AW         = 8;
   localparam int          DW         = 16;
   localparam int          TW         = 12;
   localparam int          CW         = 22;
   localparam int          HAM_P      = 5;
   localparam int          CW_H       = 21;
   localparam logic [7:0]  A_CONF0    = 8'h03;
   localparam logic [7:0]  A_CONF1    = 8'h04;
   localparam logic [7:0]  A_OSC      = 8'h05;
   localparam logic [7:0]  A_BGO      = 8'h06;
   localparam logic [7:0]  A_TEST     = 8'h10;
   localparam logic [7:0]  A_WP       = 8'h11;
   localparam logic [7:0]  NV_FIRST   = A_CONF0;
   localparam logic [7:0]  NV_LAST    = A_BGO;
   // Mode and unlock keys: arbitrary values
   localparam logic [15:0] TEST_KEY   = 16'h5A5A;
   localparam logic [15:0] WP_KEY     = 16'hA5A5;
   // Working copy of the output/relay word
   localparam int          C1_FATAL   = 0;
   localparam int          C1_REFSTOP = 1;
   localparam int          C1_BATT    = 2;
   localparam int          C1_ADCREF  = 3;
   localparam int          C1_THRSRC  = 4;
   localparam int          C1_CMPSRC  = 5;
   localparam int          C1_CMPPOL  = 6;
   localparam int          C1_BYPASS  = 7;
   localparam int          C1_RELSRC  = 8;
   localparam int          C1_RELPOL  = 9;
   localparam int          C1_MEMWE   = 10;
   localparam int          C1_TEST    = 11;
   localparam logic [15:0] C1_RESET   = 16'h0004;
   localparam logic [15:0] C1_NV_MASK = 16'h03FE;
   localparam logic [15:0] C1_WR_MASK = 16'h03FA;
   localparam logic [15:0] C1_BT_MASK = 16'h0004;
   // Pin function and linearisation word
   localparam int          C0_OBJ     = 0;
   localparam int          C0_AMB     = 2;
   localparam int          C0_CURVP   = 4;
   localparam int          C0_CURVN   = 5;
   localparam int          C0_NTC     = 6;
   localparam int          C0_OSI     = 7;
   localparam logic [15:0] C0_MASK    = 16'h07FF;
   // Offset calibration interval weights, seconds
   localparam logic [7:0]  OSI_S0     = 8'h02;
   localparam logic [7:0]  OSI_S1     = 8'h11;
   localparam logic [7:0]  OSI_S2     = 8'h43;
   localparam logic [7:0]  OSI_S3     = 8'h86;
   localparam int unsigned CLK_NS     = 25;
   localparam int unsigned SEC_NS     = 1_000_000_000;
   localparam int unsigned CYC_PER_SEC = SEC_NS / CLK_NS;
endpackage
`default_nettype wire

// [scr_cal_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_cal_timer #(
   parameter int unsigned CYC_PER_SEC = scr_pkg::CYC_PER_SEC
) (
   input  wire logic       clk,
   input  wire logic       rstSync_n,
   input  wire logic [3:0] interval,
   output logic            calStart
);
   localparam int PW = $clog2(CYC_PER_SEC);

   logic [PW-1:0] pre_q;
   logic [PW-1:0] pre_d;
   logic [7:0]    sec_q;
   logic [7:0]    sec_d;
   logic [3:0]    ivl_q;
   logic [3:0]    ivl_d;
   logic          start_q;
   logic          start_d;
   logic [7:0]    target;

   always_comb begin
      target = 8'h00;
      if (interval[0]) target = target + scr_pkg::OSI_S0;
      if (interval[1]) target = target + scr_pkg::OSI_S1;
      if (interval[2]) target = target + scr_pkg::OSI_S2;
      if (interval[3]) target = target + scr_pkg::OSI_S3;
      pre_d   = pre_q;
      sec_d   = sec_q;
      ivl_d   = interval;
      start_d = 1'b0;
      // A changed interval restarts timing; zero holds the counters so no start is ever issued
      if (interval != ivl_q || target == 8'h00) begin
         pre_d = '0;
         sec_d = 8'h00;
      end else if (pre_q == PW'(CYC_PER_SEC - 1)) begin
         pre_d = '0;
         if (sec_q == target - 8'h01) begin
            sec_d   = 8'h00;
            start_d = 1'b1;
         end else begin
            sec_d = sec_q + 8'h01;
         end
      end else begin
         pre_d = pre_q + PW'(1);
      end
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pre_q   <= '0;
         sec_q   <= 8'h00;
         ivl_q   <= 4'h0;
         start_q <= 1'b0;
      end else begin
         pre_q   <= pre_d;
         sec_q   <= sec_d;
         ivl_q   <= ivl_d;
         start_q <= start_d;
      end
   end

   assign calStart = start_q;
endmodule
`default_nettype wire

// [scr_nvm_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scr_nvm_model (
   input  wire logic        clk,
   input  wire logic [7:0]  nvmAddr,
   input  wire logic        nvmRdEn,
   input  wire logic        nvmWrEn,
   input  wire logic [21:0] nvmWrData,
   output logic [21:0]      nvmRdData
);
   logic [21:0] mem [256];
   // Idle data lines toggle every cycle so a sample one cycle late sees the last word inverted
   always @(posedge clk) begin
      if (nvmWrEn) begin
         mem[nvmAddr] <= nvmWrData;
      end
      if (nvmRdEn) begin
         nvmRdData <= mem[nvmAddr];
      end else begin
         nvmRdData <= ~nvmRdData;
      end
   end
   function automatic logic [21:0] enc(input logic [15:0] d);
      logic [21:0] c;
      int          j;
      c = '0;
      j = 0;
      for (int p = 1; p < 22; p++) begin
         if ((p & (p - 1)) != 0) begin
            c[p-1] = d[j];
            j++;
         end
      end
      // Each check bit is first in its own group, so it is still zero when summed
      for (int k = 0; k < 5; k++) begin
         for (int p = 1; p < 22; p++) begin
            if (p[k]) begin
               c[(1 << k) - 1] ^= c[p-1];
            end
         end
      end
      c[21] = ^c[20:0];
      return c;
   endfunction
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk, rst_n, regWr, regRd, regNv, regBusy, regRdValid, nvmRdEn, nvmWrEn;
   logic        converterRegulatorOn, convRefDriveEn, convRefPinInput, batteryRegulatorOn;
   logic        adcRefInternal, relayThrFromPin, tempChainBypass, memWriteEnabledFlag;
   logic        testModeFlag, fatalErrorFlag, thermistorNtc, curvatureNegative;
   logic        offsetCalStart, outputComparator, outputRelay;
   logic [7:0]  regAddr, nvmAddr;
   logic [15:0] regWrData, regRdData, oscillator_control, refTrim, v;
   logic [21:0] nvmWrData, nvmRdData;
   logic [11:0] objTemp, ambTemp, compThreshold, relayThrNvm, relayThrPin;
   logic [3:0]  objPinSel, ambPinSel;
   int          miscompares = 0;
   int          checks = 0;
   int          n;
   wire  [15:0] flags = {batteryRegulatorOn, adcRefInternal, relayThrFromPin, tempChainBypass,
                         convRefPinInput, convRefDriveEn, testModeFlag, memWriteEnabledFlag,
                         fatalErrorFlag, thermistorNtc, curvatureNegative, 5'h00};
   scr_config_regs #(.CYC_PER_SEC(4)) DUT (.*);
   scr_nvm_model nvm (.*);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic final_report;
      if (miscompares == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      final_report;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Status is looked at just after the edge, never in its own time step
   task automatic idle;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (regBusy !== 1'b0 && n < 40);
      chk(16'(regBusy), 16'h0000);
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic nv);
      regAddr <= a;
      regWrData <= d;
      regNv <= nv;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      idle;
   endtask
   task automatic rd(input logic [7:0] a, input logic nv, input logic [15:0] exp);
      regAddr <= a;
      regNv <= nv;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      n = 0;
      #1;
      // A direct answer stands from the take edge, an NV answer two edges later
      while (regRdValid !== 1'b1 && n < 6) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(n), nv ? 16'h0002 : 16'h0000);
      chk(regRdData, exp);
      idle;
   endtask
   task automatic pulse;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (offsetCalStart !== 1'b1 && n < 1000);
   endtask
   // A zero interval must stay silent for the whole wait
   task automatic tmr(input logic [3:0] c);
      int e;
      e = 4 * ((c[0] ? scr_pkg::OSI_S0 : 8'h00) + (c[1] ? scr_pkg::OSI_S1 : 8'h00)
             + (c[2] ? scr_pkg::OSI_S2 : 8'h00) + (c[3] ? scr_pkg::OSI_S3 : 8'h00));
      wr(8'h03, {5'h00, c, 7'h16}, 1'b0);
      pulse;
      pulse;
      chk(16'(n), 16'(e == 0 ? 1000 : e));
      @(posedge clk);
   endtask
   function automatic logic cmpx(input logic [11:0] t, input logic [11:0] th, input logic pol);
      return (t > th) ~^ pol;
   endfunction
   initial begin
      rst_n <= 1'b0;
      regWr <= 1'b0;
      regRd <= 1'b0;
      regNv <= 1'b0;
      regAddr <= 8'h00;
      regWrData <= 16'h0000;
      converterRegulatorOn <= 1'b1;
      objTemp <= 12'h600;
      ambTemp <= 12'h100;
      compThreshold <= 12'h400;
      relayThrNvm <= 12'h400;
      relayThrPin <= 12'h700;
      nvm.mem[3] = nvm.enc(16'h0016);
      nvm.mem[4] = nvm.enc(16'h0C9B);
      // Two flipped bits cannot be repaired, one can
      nvm.mem[5] = nvm.enc(16'h1234) ^ 22'h000204;
      nvm.mem[6] = nvm.enc(16'hBEEF) ^ 22'h000020;
      repeat (10) @(posedge clk);
      chk(16'(batteryRegulatorOn), 16'h0001);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      idle;
      chk(flags, 16'h78A0);
      chk({8'h00, ambPinSel, objPinSel}, 16'h0024);
      chk(refTrim, 16'hBEEF);
      chk(oscillator_control, 16'h0000);
      rd(8'h04, 1'b0, 16'h009B);
      rd(8'h04, 1'b1, 16'h0C9B);
      rd(8'h06, 1'b1, 16'hBEEF);
      rd(8'h05, 1'b0, 16'h0000);
      rd(8'h20, 1'b0, 16'h0000);
      wr(8'h04, 16'h0000, 1'b0);
      wr(8'h05, 16'h1111, 1'b0);
      wr(8'h04, 16'h1234, 1'b1);
      rd(8'h04, 1'b0, 16'h009B);
      rd(8'h04, 1'b1, 16'h0C9B);
      chk(oscillator_control, 16'h0000);
      wr(8'h10, scr_pkg::TEST_KEY, 1'b0);
      chk(16'(testModeFlag), 16'h0001);
      wr(8'h05, 16'h1357, 1'b0);
      wr(8'h06, 16'h2468, 1'b0);
      chk(oscillator_control, 16'h1357);
      chk(refTrim, 16'h2468);
      for (int i = 0; i < 4; i++) begin
         wr(8'h04, {6'h00, i[1], i[0], 1'b0, i[1], i[0], i[0], 4'h0}, 1'b0);
         #1;
         v[1] = cmpx(i[0] ? ambTemp : objTemp, compThreshold, i[1]);
         v[0] = cmpx(i[0] ? ambTemp : objTemp, i[0] ? relayThrPin : relayThrNvm, i[1]);
         chk({13'h0, relayThrFromPin, outputComparator, outputRelay}, {13'h0, i[0], v[1:0]});
         chk({14'h0, convRefPinInput, convRefDriveEn}, 16'h0001);
         @(posedge clk);
      end
      converterRegulatorOn <= 1'b0;
      @(posedge clk);
      #1;
      chk({14'h0, convRefPinInput, convRefDriveEn}, 16'h0002);
      @(posedge clk);
      converterRegulatorOn <= 1'b1;
      wr(8'h04, 16'hFFFF, 1'b0);
      rd(8'h04, 1'b0, 16'h0BFB);
      for (int c = 0; c < 4; c++) begin
         wr(8'h03, {9'h000, c[0], !c[1], c[1], c[1:0], c[1:0]}, 1'b0);
         #1;
         chk({6'h00, thermistorNtc, curvatureNegative, ambPinSel, objPinSel}, {6'h00, c[0], c[0] ^ c[1], 8'h11 << c});
         @(posedge clk);
      end
      tmr(4'h1);
      tmr(4'h2);
      tmr(4'h4);
      tmr(4'hF);
      tmr(4'h0);
      wr(8'h11, scr_pkg::WP_KEY, 1'b0);
      chk(16'(memWriteEnabledFlag), 16'h0001);
      wr(8'h06, 16'h9ABC, 1'b1);
      rd(8'h06, 1'b1, 16'h9ABC);
      wr(8'h10, 16'h0000, 1'b0);
      chk({14'h0, testModeFlag, fatalErrorFlag}, 16'h0000);
      // The uncorrectable word comes back uncorrected and raises the flag again
      rd(8'h05, 1'b1, 16'h1215);
      chk(16'(fatalErrorFlag), 16'h0001);
      wr(8'h06, 16'h1111, 1'b1);
      rd(8'h06, 1'b1, 16'h9ABC);
      wr(8'h03, 16'h0555, 1'b1);
      rd(8'h03, 1'b1, 16'h0555);
      wr(8'h10, scr_pkg::TEST_KEY, 1'b0);
      wr(8'h05, 16'h4321, 1'b1);
      rd(8'h05, 1'b1, 16'h4321);
      final_report;
   end
endmodule
`default_nettype wire
